// ---- adc_read_pkg.sv ----
// Constants and types for the ADC result read-back port
// What this block does
// - Results load from new conversion at busy fall
// - Reads after busy fall return fresh results
// - Reads during busy return the previous results
// - Two straps pick word, byte or serial mode
// - Word mode drives bus from chip-select fall
// - First fall gives channel 1, then next
// - First-channel flag high only for channel 1
// - Chip-select held low, read strobe alone steps
// - Chip-select fall enables bus, reads step channels
// - Byte mode sends each result as two bytes
// - Byte order input picks upper or lower first
// - Byte mode drives low bus half only
// - Byte flag spans two reads, drops at third
// - Bus and flag float when chip-select goes high
// - Busy rises at conversion start until done
package adc_read_pkg;
  localparam int N_CH        = 8;
  localparam int WORD_W      = 16;
  localparam int BYTE_W      = 8;
  localparam int FIFO_DEPTH  = 8;
  localparam int PTR_W       = 4;
  localparam int CH_W        = 3;
  localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
  localparam logic [PTR_W-1:0] ALL_IN    = 4'h8;
  localparam logic [15:0] OE_WORD  = 16'hffff;
  localparam logic [15:0] OE_BYTE  = 16'h00ff;
  localparam logic [15:0] OE_NONE  = 16'h0000;
  localparam logic [15:0] DB_RESET = 16'h0000;
  localparam logic [PTR_W-1:0] WORD_FIRST_END = 4'h1;
  localparam logic [PTR_W-1:0] BYTE_FIRST_END = 4'h2;

  typedef enum logic [1:0] {
    MODE_WORD,
    MODE_BYTE,
    MODE_SERIAL
  } mode_t;
endpackage

// ---- adc_read_port.sv ----
// Result FIFO and parallel read-back port of the ADC
`timescale 1ns/1ps

// ============================================================
// Sample FIFO
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        room;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic        push;
  logic        pop;

  assign in_ready  = q.room;
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];

  always_comb begin
    d    = q;
    push = in_valid && q.room;
    pop  = out_ready && (q.cnt != '0);
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt  = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    d.room = (d.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q      <= '0;
      q.room <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ============================================================
  // Checks
  a_fifo_bound: assert property (@(posedge clk_sys) disable iff (reset)
    q.cnt <= (AW+1)'(DEPTH))
    else $error("sample FIFO count above its depth");

  a_fifo_push: assert property (@(posedge clk_sys) disable iff (reset)
    push && !pop |=> q.cnt == $past(q.cnt) + 1'b1)
    else $error("sample FIFO count not raised on push");

  a_fifo_pop: assert property (@(posedge clk_sys) disable iff (reset)
    pop && !push |=> q.cnt == $past(q.cnt) - 1'b1)
    else $error("sample FIFO count not lowered on pop");

  a_fifo_keep: assert property (@(posedge clk_sys) disable iff (reset)
    !push |=> $stable(q.mem))
    else $error("sample FIFO storage changed without push");
endmodule

// ============================================================
// Read-back port
module adc_read_port
  import adc_read_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        interface_select,
  input  wire logic        byte_serial_select,
  input  wire logic        byte_order_select,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        conv_start,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  output logic             sample_ready,
  output logic             busy,
  output logic      [15:0] db_out,
  output logic      [15:0] db_oe,
  output logic             first_channel_flag_out,
  output logic             first_channel_flag_oe
);
  typedef struct packed {
    logic [1:0]                       is_s;
    logic [1:0]                       bs_s;
    logic [1:0]                       bo_s;
    logic [2:0]                       cs_s;
    logic [2:0]                       rd_s;
    logic                             busy;
    logic [PTR_W-1:0]                 widx;
    logic [PTR_W-1:0]                 ptr;
    logic [N_CH-1:0][WORD_W-1:0]      res;
    logic [N_CH-1:0][WORD_W-1:0]      shd;
    logic [15:0]                      db;
    logic [15:0]                      oe;
    logic                             frst;
  } port_state_t;

  port_state_t      q;
  port_state_t      d;
  mode_t            mode;
  logic             cs_low;
  logic             rd_fall;
  logic             step;
  logic             f_valid;
  logic [15:0]      f_data;
  logic             f_ready;
  logic [CH_W-1:0]  ch;
  logic [WORD_W-1:0] word;

  // Samples queue here so the core can run ahead of the result bank
  sample_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (sample_valid),
    .in_data   (sample_data),
    .in_ready  (sample_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_ready)
  );

  // ============================================================
  // Mode and strobe decode
  always_comb begin
    if (!q.is_s[1]) begin
      mode = MODE_WORD;
    end else if (q.bs_s[1]) begin
      mode = MODE_BYTE;
    end else begin
      mode = MODE_SERIAL;
    end
  end

  assign cs_low  = !q.cs_s[1];
  // Joined strobes fall together, so one edge serves both cases
  assign rd_fall = q.rd_s[2] && !q.rd_s[1] && cs_low;
  assign step    = rd_fall && (mode != MODE_SERIAL);
  // Drain runs only while busy and stalls at eight words, so the FIFO fills while idle
  assign f_ready = q.busy && (q.widx != ALL_IN);

  // ============================================================
  // Next state
  always_comb begin
    d      = q;
    d.is_s = {q.is_s[0], interface_select};
    d.bs_s = {q.bs_s[0], byte_serial_select};
    d.bo_s = {q.bo_s[0], byte_order_select};
    d.cs_s = {q.cs_s[1:0], cs_n};
    d.rd_s = {q.rd_s[1:0], rd_n};
    ch     = (mode == MODE_BYTE) ? q.ptr[3:1] : q.ptr[2:0];
    word   = q.res[ch];

    if (conv_start && !q.busy) begin
      d.busy = 1'b1;
      d.widx = PTR_RESET;
    end
    if (f_valid && f_ready) begin
      d.shd[q.widx[CH_W-1:0]] = f_data;
      d.widx                  = q.widx + 1'b1;
    end
    // Bank swap wins; a read edge in the same cycle is lost
    if (q.busy && q.widx == ALL_IN) begin
      d.busy = 1'b0;
      d.res  = q.shd;
      d.ptr  = PTR_RESET;
      d.frst = 1'b0;
    end else if (step) begin
      // Channels ascend; past the last they wrap back to channel 1
      d.ptr = q.ptr + 1'b1;
      if (mode == MODE_WORD) begin
        d.db   = word;
        d.frst = (q.ptr < WORD_FIRST_END);
      end else begin
        d.db[15:8] = '0;
        if (q.ptr[0] ^ q.bo_s[1]) begin
          d.db[7:0] = word[15:8];
        end else begin
          d.db[7:0] = word[7:0];
        end
        d.frst = (q.ptr < BYTE_FIRST_END);
      end
    end

    if (!cs_low || mode == MODE_SERIAL) begin
      d.oe = OE_NONE;
    end else if (mode == MODE_WORD) begin
      d.oe = OE_WORD;
    end else begin
      d.oe = OE_BYTE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q      <= '0;
      q.cs_s <= 3'h7;
      q.rd_s <= 3'h7;
      q.ptr  <= PTR_RESET;
      q.db   <= DB_RESET;
      q.oe   <= OE_NONE;
    end else begin
      q <= d;
    end
  end

  assign busy                   = q.busy;
  assign db_out                 = q.db;
  assign db_oe                  = q.oe;
  assign first_channel_flag_out = q.frst;
  assign first_channel_flag_oe  = q.oe[0];

  // ============================================================
  // Checks
  sequence s_word_read;
    step && mode == MODE_WORD;
  endsequence

  sequence s_byte_read;
    step && mode == MODE_BYTE;
  endsequence

  sequence s_bank_swap;
    q.busy && q.widx == ALL_IN;
  endsequence

  a_busy_rise: assert property (@(posedge clk_sys) disable iff (reset)
    conv_start && !q.busy |=> q.busy)
    else $error("busy did not rise on conversion start");

  a_bank_load: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(q.busy) |-> q.res == $past(q.shd))
    else $error("results not loaded at busy fall");

  a_bank_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !$fell(q.busy) |-> $stable(q.res))
    else $error("results changed outside busy fall");

  a_fresh_start: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(q.busy) |-> q.ptr == PTR_RESET && !q.frst)
    else $error("read sequence not restarted at busy fall");

  a_word_data: assert property (@(posedge clk_sys) disable iff (reset)
    s_word_read ##0 !(q.busy && q.widx == ALL_IN) |=> q.db == q.res[$past(q.ptr[2:0])])
    else $error("word bus shows wrong channel");

  a_word_flag: assert property (@(posedge clk_sys) disable iff (reset)
    s_word_read ##0 (q.ptr == PTR_RESET) ##1 !step [*2] |-> q.frst)
    else $error("first channel flag not held for channel 1");

  a_word_drive: assert property (@(posedge clk_sys) disable iff (reset)
    cs_low && mode == MODE_WORD |=> q.oe == OE_WORD)
    else $error("word bus not driven with chip-select low");

  a_byte_order: assert property (@(posedge clk_sys) disable iff (reset)
    s_byte_read ##0 (q.ptr == PTR_RESET && q.bo_s[1] && !q.busy) |=> q.db[7:0] == q.res[0][15:8])
    else $error("byte order input not honoured");

  a_byte_flag: assert property (@(posedge clk_sys) disable iff (reset)
    s_byte_read ##0 (q.ptr == BYTE_FIRST_END && !q.busy) |=> !q.frst)
    else $error("flag not low at third byte read");

  a_byte_lanes: assert property (@(posedge clk_sys) disable iff (reset)
    cs_low && mode == MODE_BYTE |=> q.oe == OE_BYTE)
    else $error("byte mode drives wrong lanes");

  a_bus_float: assert property (@(posedge clk_sys) disable iff (reset)
    !cs_low |=> q.oe == OE_NONE && !first_channel_flag_oe)
    else $error("bus driven with chip-select high");

  a_busy_fall: assert property (@(posedge clk_sys) disable iff (reset)
    s_bank_swap |=> !q.busy)
    else $error("busy not dropped after last word");

  a_busy_hold: assert property (@(posedge clk_sys) disable iff (reset)
    q.busy && q.widx != ALL_IN |=> q.busy)
    else $error("busy dropped before all words collected");

  a_serial_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    mode == MODE_SERIAL |=> q.oe == OE_NONE)
    else $error("bus driven in serial mode");

  a_serial_still: assert property (@(posedge clk_sys) disable iff (reset)
    mode == MODE_SERIAL && !(q.busy && q.widx == ALL_IN) |=> $stable(q.ptr))
    else $error("read pointer moved in serial mode");

  a_cs_refuse: assert property (@(posedge clk_sys) disable iff (reset)
    !cs_low && !(q.busy && q.widx == ALL_IN) |=> $stable(q.ptr))
    else $error("read pointer moved with chip-select high");

  a_cs_flag_drive: assert property (@(posedge clk_sys) disable iff (reset)
    cs_low && mode != MODE_SERIAL |=> first_channel_flag_oe)
    else $error("first channel flag not driven with chip-select low");

  a_step_advance: assert property (@(posedge clk_sys) disable iff (reset)
    step && !(q.busy && q.widx == ALL_IN) |=> q.ptr == $past(q.ptr) + 4'h1)
    else $error("read pointer did not ascend on a read edge");

  a_data_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !step |=> $stable(q.db))
    else $error("bus data changed without a read edge");

  a_word_later_flag: assert property (@(posedge clk_sys) disable iff (reset)
    s_word_read ##0 (q.ptr != PTR_RESET && !(q.busy && q.widx == ALL_IN)) |=> !q.frst)
    else $error("first channel flag high past channel 1");

  a_byte_low_first: assert property (@(posedge clk_sys) disable iff (reset)
    s_byte_read ##0 (q.ptr == PTR_RESET && !q.bo_s[1] && !q.busy) |=> q.db[7:0] == q.res[0][7:0])
    else $error("lower byte not sent first");

  a_byte_second: assert property (@(posedge clk_sys) disable iff (reset)
    s_byte_read ##0 (q.ptr == 4'h1 && q.bo_s[1] && !q.busy) |=> q.db[7:0] == q.res[0][7:0])
    else $error("second byte of channel 1 wrong");

  a_byte_upper_zero: assert property (@(posedge clk_sys) disable iff (reset)
    s_byte_read ##0 !(q.busy && q.widx == ALL_IN) |=> q.db[15:8] == 8'h00)
    else $error("upper bus half not cleared in byte mode");

  a_byte_first_flag: assert property (@(posedge clk_sys) disable iff (reset)
    s_byte_read ##0 (q.ptr < BYTE_FIRST_END && !(q.busy && q.widx == ALL_IN)) |=> q.frst)
    else $error("flag not high over both channel 1 bytes");
endmodule

// ---- adc_host_model.sv ----
// Host model that strobes results out of the read-back port
`timescale 1ns/1ps

// ============================================================
// Host
module adc_host_model (
  input  wire logic        clk_sys,
  input  wire logic        go,
  input  wire logic        joined,
  input  wire logic [4:0]  n_reads,
  input  wire logic [15:0] db_out,
  input  wire logic [15:0] db_oe,
  input  wire logic        flag,
  input  wire logic        flag_oe,
  output logic             cs_n,
  output logic             rd_n,
  output logic             done,
  output logic      [15:0] cap_d [16],
  output logic      [15:0] cap_oe [16],
  output logic      [15:0] cap_f
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    done = 1'b0;
    cap_f = 16'h0000;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        done <= 1'b0;
        // Shared bus style: chip-select framed apart from reads
        if (!joined) begin
          cs_n <= 1'b0;
          repeat (4) @(posedge clk_sys);
        end
        // Pulse count chosen by the bench, sixteen in byte mode
        for (int i = 0; i < n_reads; i++) begin
          rd_n <= 1'b0;
          if (joined) cs_n <= 1'b0;
          // Pins pass two sync stages, so capture late in the low phase
          repeat (5) @(posedge clk_sys);
          // Undriven lines read back inverted, so a stale value cannot pass
          cap_d[i] = (db_out & db_oe) | (~db_out & ~db_oe);
          cap_oe[i] = db_oe;
          cap_f[i] = flag_oe ? flag : !flag;
          rd_n <= 1'b1;
          if (joined) cs_n <= 1'b1;
          repeat (5) @(posedge clk_sys);
        end
        cs_n <= 1'b1;
        done <= 1'b1;
      end
    end
  end
endmodule

// ---- adc_read_port_bench.sv ----
// Self-checking bench for the ADC result read-back port
`timescale 1ns/1ps

module adc_read_port_bench
  import adc_read_pkg::*;
;
  logic        clk_sys, reset, isel, bsel, osel, conv_start, sample_valid, go, joined, sample_ready, busy, f_out, f_oe;
  logic        cs_n, rd_n, done;
  logic [4:0]  n_rd;
  logic [15:0] sample_data, db_out, db_oe, cap_f;
  logic [15:0] cap_d [16];
  logic [15:0] cap_oe [16];
  logic [15:0] cur [8];
  logic [15:0] nxt [8];
  logic [31:0] seed = 32'h6047;
  int          miscompares = 0;
  int          n_checks = 0;

  adc_read_port adc_read_port_i (.clk_sys(clk_sys), .reset(reset), .interface_select(isel),
    .byte_serial_select(bsel), .byte_order_select(osel), .cs_n(cs_n), .rd_n(rd_n), .conv_start(conv_start),
    .sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready), .busy(busy),
    .db_out(db_out), .db_oe(db_oe), .first_channel_flag_out(f_out), .first_channel_flag_oe(f_oe));
  adc_host_model adc_host_model_i (.clk_sys(clk_sys), .go(go), .joined(joined), .n_reads(n_rd), .db_out(db_out),
    .db_oe(db_oe), .flag(f_out), .flag_oe(f_oe), .cs_n(cs_n), .rd_n(rd_n), .done(done),
    .cap_d(cap_d), .cap_oe(cap_oe), .cap_f(cap_f));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Byte mode: item i is a byte of channel i/2, upper first when order is high
  function automatic logic [15:0] exp_item(input logic b, input logic o, input int i);
    if (!b) return cur[i];
    return ((i % 2 == 0) == o) ? {8'h00, cur[i/2][15:8]} : {8'h00, cur[i/2][7:0]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic start();
    conv_start <= 1'b1;
    @(posedge clk_sys);
    conv_start <= 1'b0;
    @(negedge clk_sys);
    chk("busy rise", 16'(busy), 16'h0001);
    @(posedge clk_sys);
  endtask

  task automatic push8();
    for (int k = 0; k < 8; k++) begin
      nxt[k] = 16'(rnd());
      sample_valid <= 1'b1;
      sample_data <= nxt[k];
      @(posedge clk_sys);
    end
    sample_valid <= 1'b0;
  endtask

  task automatic finish(input logic push);
    int n;
    if (push) push8();
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    chk("busy fall", 16'(n < 100), 16'h0001);
    @(posedge clk_sys);
    cur = nxt;
  endtask

  task automatic rd(input logic j, input logic b, input logic o, input logic s, input logic [4:0] n);
    int k;
    logic [31:0] r;
    r = rnd();
    isel <= b | s;
    // Word mode ignores the second strap, so it is drawn at random there
    bsel <= s ? 1'b0 : (b | r[0]);
    osel <= o;
    repeat (6) @(posedge clk_sys);
    joined <= j;
    n_rd <= n;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    // Done of the previous frame must clear before it is watched
    @(negedge clk_sys);
    k = 0;
    while (done !== 1'b1 && k < 2000) begin
      @(negedge clk_sys);
      k++;
    end
    chk("read done", 16'(k < 2000), 16'h0001);
    for (int i = 0; i < n; i++) begin
      if (s) begin
        chk("serial oe", cap_oe[i], OE_NONE);
      end else begin
        chk("data", b ? {8'h00, cap_d[i][7:0]} : cap_d[i], exp_item(b, o, i));
        chk("oe", cap_oe[i], b ? OE_BYTE : OE_WORD);
        chk("flag", 16'(cap_f[i]), 16'((b ? 2 : 1) > i));
      end
    end
    repeat (4) @(negedge clk_sys);
    chk("idle oe", db_oe, OE_NONE);
    chk("idle flag oe", 16'(f_oe), 16'h0000);
    @(posedge clk_sys);
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end

  initial begin
    {isel, bsel, osel, conv_start, sample_valid, go, joined} = '0;
    n_rd = 5'h00;
    sample_data = 16'h0000;
    reset = 1'b1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk("reset busy", 16'(busy), 16'h0000);
    chk("reset oe", db_oe, OE_NONE);
    chk("reset flag oe", 16'(f_oe), 16'h0000);
    chk("reset ready", 16'(sample_ready), 16'h0001);
    repeat (3) @(posedge clk_sys);
    start();
    finish(1'b1);
    start();
    // Pointer restarts at the busy fall, old bank still shown mid-conversion
    rd(1'b0, 1'b0, 1'b0, 1'b0, 5'h08);
    finish(1'b1);
    // Byte high-first, byte low-first, word joined, word with cs held apart
    for (int t = 0; t < 4; t++) begin
      start();
      finish(1'b1);
      rd(t == 2, t < 2, t == 0, 1'b0, (t < 2) ? 5'h10 : 5'h08);
    end
    rd(1'b0, 1'b0, 1'b0, 1'b1, 5'h02);
    // Words queued while idle fill the FIFO and wait for the start
    push8();
    @(negedge clk_sys);
    chk("fifo full", 16'(sample_ready), 16'h0000);
    @(posedge clk_sys);
    start();
    finish(1'b0);
    rd(1'b1, 1'b0, 1'b0, 1'b0, 5'h08);
    print_verdict();
  end
endmodule
